/* hw/vio_link.sv */
// Virtual I/O link: cyclic 32-bit exchange with a peer, APB registers, indicators.
// Functional notes
// - Carry 32 output bits to the peer and 32 peer bits back as inputs.
// - One module per connection; signals are refreshed cyclically, not on demand.
// - A fresh output set is sent to the peer with the next frame.
// - Output to peer input within 35 ms.
// - Output bit k arrives as input bit k.
// - Pair A of one module is wired to pair B of the other.
// - Two redundant channels supervise each other.
// - On link loss inputs go to zero and controllers keep running.
// - A defective module stops its controller and zeroes its outputs.
// - Report own health, connection present, and peer run state.
// - Ready indicator on while operational, off otherwise.
// - Link-active indicator on while connected.
`timescale 1ns/10ps
`default_nettype none
`include "vio_link_consts.svh"
module vio_link (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // Controller side.
  input wire logic I_CTRL_RUN,
  input wire logic I_POWER_OK,
  output logic O_CTRL_STOP,
  output logic O_IRQ,
  // Link pairs, A transmits and B receives.
  output logic O_PAIR_A_POSITIVE,
  input wire logic I_PAIR_B_POSITIVE,
  // Indicators.
  output logic O_READY_LED,
  output logic O_LINK_ACTIVE_INDICATOR,
  output logic O_FAULT_LED,
  // Visible health for the controller.
  output vio_link_pkg::health_t O_HEALTH
);
  import vio_link_pkg::*;

  localparam int NB = `VL_NBITS;
  localparam int FB = `VL_FRAME_BITS;
  localparam logic [31:0] TOUT = 32'(`VL_TOUT_CYC);

  // Registers.
  logic [NB-1:0] out_a_ff, out_b_ff;
  logic [NB-1:0] in_ff;
  logic fresh_ff, conn_ff, seen_ff, peer_run_ff, defect_ff;
  logic [3:0] irq_st_ff, irq_mask_ff;
  logic ctrl_run_ff;
  tx_state_t tx_ff;
  logic [FB-1:0] txsh_ff, rxsh_ff;
  logic [6:0] txcnt_ff;
  logic [3:0] div_ff;
  logic [31:0] tout_ff;
  logic rx_d_ff;

  // Decode.
  wire wr = I_PSEL && I_PENABLE && I_PWRITE;
  wire rd_sel = I_PSEL && !I_PENABLE && !I_PWRITE;
  wire a_ctrl = I_PADDR == `VL_ADDR_CTRL;
  wire a_out = I_PADDR == `VL_ADDR_OUT;
  wire a_in = I_PADDR == `VL_ADDR_IN;
  wire a_st = I_PADDR == `VL_ADDR_STAT;
  wire a_is = I_PADDR == `VL_ADDR_IRQ_STAT;
  wire a_im = I_PADDR == `VL_ADDR_IRQ_MASK;
  wire mapped = a_ctrl | a_out | a_in | a_st | a_is | a_im;
  wire bit_tick = div_ff == 4'(`VL_BIT_DIV - 1);
  // Output write: the controller's end-of-cycle handover, stored in both channels.
  wire out_wr = wr && a_out && !defect_ff;
  // The two channels must agree; any mismatch is taken as a module defect.
  wire chan_mismatch = out_a_ff != out_b_ff;
  wire go_defect = chan_mismatch || !I_POWER_OK;
  health_t health;
  assign health = !I_POWER_OK ? HEALTH_UNPOWERED : (defect_ff ? HEALTH_DEFECT : HEALTH_GOOD);
  // Frame: sync nibble, peer flags, 32 bits in index order, inverted copy of the bits.
  wire [NB-1:0] tx_bits = defect_ff ? '0 : out_a_ff;
  wire [FB-1:0] frame = {`VL_SYNC_WORD, ctrl_run_ff, defect_ff, tx_bits, ~tx_bits};
  wire [NB-1:0] rx_bits = rxsh_ff[2*NB-1:NB];
  wire rx_ok = rxsh_ff[FB-1:FB-4] == `VL_SYNC_WORD && rx_bits == ~rxsh_ff[NB-1:0];
  wire rx_peer_def = rxsh_ff[FB-6];
  wire rx_peer_run = rxsh_ff[FB-5];
  wire rx_take = bit_tick && rx_ok;
  wire timed_out = tout_ff == TOUT;
  wire [3:0] ev = {rx_take, go_defect && !defect_ff, timed_out && conn_ff, rx_take && !conn_ff};
  wire [31:0] status = {28'h0000000, peer_run_ff, conn_ff, health};
  wire [31:0] rd_mux =
    a_ctrl ? {30'h00000000, fresh_ff, ctrl_run_ff} :
    a_out ? out_a_ff :
    a_in ? in_ff :
    a_st ? status :
    a_is ? {28'h0000000, irq_st_ff} :
    a_im ? {28'h0000000, irq_mask_ff} : 32'h00000000;

  // APB answers in the access phase with zero wait states.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !mapped;
      if (rd_sel) begin
        O_PRDATA <= rd_mux;
      end
    end
  end

  // Redundant copies of the output set.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      out_a_ff <= 32'h00000000;
      out_b_ff <= 32'h00000000;
      fresh_ff <= 1'b0;
      ctrl_run_ff <= 1'b0;
    end else begin
      if (defect_ff) begin
        out_a_ff <= 32'h00000000;
        out_b_ff <= 32'h00000000;
      end else if (out_wr) begin
        out_a_ff <= I_PWDATA;
        out_b_ff <= I_PWDATA;
      end
      ctrl_run_ff <= I_CTRL_RUN;
      if (out_wr) begin
        fresh_ff <= 1'b1;
      end else if (tx_ff == TX_LOAD) begin
        fresh_ff <= 1'b0;
      end
    end
  end

  // Defect is latched until reset; the controller is told to stop.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      defect_ff <= 1'b0;
      O_CTRL_STOP <= 1'b0;
      O_FAULT_LED <= 1'b0;
      O_HEALTH <= HEALTH_UNPOWERED;
    end else begin
      if (go_defect) begin
        defect_ff <= 1'b1;
      end
      O_CTRL_STOP <= defect_ff;
      O_FAULT_LED <= defect_ff;
      O_HEALTH <= health;
    end
  end

  // Bit-rate divider.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= bit_tick ? 4'h0 : div_ff + 4'h1;
    end
  end

  // Transmitter sends frames back to back when a fresh set is pending, else one bit time apart; a fresh set is loaded at the next frame start.
  // A frame is 70 bits of 16 cycles, so any set leaves well inside the transfer budget.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tx_ff <= TX_IDLE;
      txsh_ff <= '0;
      txcnt_ff <= 7'h00;
      O_PAIR_A_POSITIVE <= 1'b0;
    end else begin
      case (tx_ff)
        TX_IDLE: begin
          if (bit_tick) begin
            tx_ff <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          txsh_ff <= frame;
          txcnt_ff <= 7'h00;
          tx_ff <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (bit_tick) begin
            O_PAIR_A_POSITIVE <= txsh_ff[FB-1];
            txsh_ff <= {txsh_ff[FB-2:0], 1'b0};
            txcnt_ff <= txcnt_ff + 7'h01;
            if (txcnt_ff == 7'(FB - 1)) begin
              tx_ff <= TX_GAP;
            end
          end
        end
        TX_GAP: begin
          tx_ff <= fresh_ff ? TX_LOAD : TX_IDLE;
        end
        default: begin
          tx_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // Receiver samples once per bit and checks the sliding window for a valid frame.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rx_d_ff <= 1'b0;
      rxsh_ff <= '0;
      in_ff <= 32'h00000000;
      seen_ff <= 1'b0;
      conn_ff <= 1'b0;
      peer_run_ff <= 1'b0;
      tout_ff <= 32'h00000000;
    end else begin
      rx_d_ff <= I_PAIR_B_POSITIVE;
      if (rx_take) begin
        // The bit sampled on this tick may open the next frame, so it is kept, not dropped.
        rxsh_ff <= {{(FB-1){1'b0}}, rx_d_ff};
      end else if (bit_tick) begin
        rxsh_ff <= {rxsh_ff[FB-2:0], rx_d_ff};
      end
      if (rx_take) begin
        tout_ff <= 32'h00000000;
        conn_ff <= 1'b1;
        seen_ff <= 1'b1;
        // A defective peer sends zeros and is reported as stopped.
        peer_run_ff <= rx_peer_run && !rx_peer_def;
      end else if (timed_out) begin
        conn_ff <= 1'b0;
        peer_run_ff <= 1'b0;
      end else begin
        tout_ff <= tout_ff + 32'h00000001;
      end
      if (!conn_ff || !seen_ff) begin
        in_ff <= 32'h00000000;
      end
      if (rx_take) begin
        in_ff <= rx_bits;
      end
    end
  end

  // Interrupt status and mask; set wins over write-one-to-clear.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      irq_st_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      O_IRQ <= 1'b0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~((wr && a_is) ? I_PWDATA[3:0] : 4'h0)) | ev;
      if (wr && a_im) begin
        irq_mask_ff <= I_PWDATA[3:0];
      end
      O_IRQ <= |(irq_st_ff & irq_mask_ff);
    end
  end

  // Indicators.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_READY_LED <= 1'b0;
      O_LINK_ACTIVE_INDICATOR <= 1'b0;
    end else begin
      O_READY_LED <= I_POWER_OK && !defect_ff;
      O_LINK_ACTIVE_INDICATOR <= conn_ff;
    end
  end

  property p_defect_zero;
    @(posedge I_CLK) disable iff (!I_RESET_N) defect_ff |=> out_a_ff == 32'h00000000;
  endproperty
  defect_zeroes_out_a: assert property (p_defect_zero) else $error("outputs not zeroed on defect");
  stop_follows_defect_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(defect_ff) |=> O_CTRL_STOP) else $error("stop not raised");
  lost_inputs_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (!conn_ff && !rx_take) |=> in_ff == 32'h00000000) else $error("inputs not zero when lost");
  first_frame_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !seen_ff |-> in_ff == 32'h00000000) else $error("inputs before first frame");
  rx_bit_order_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    rx_take |=> in_ff == $past(rx_bits)) else $error("bit order broken");
  // A pending set may wait a whole frame, longer than a delay range can span, so the wait is counted.
  logic [11:0] fresh_wait_ff;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fresh_wait_ff <= 12'h000;
    end else if (!fresh_ff || tx_ff == TX_LOAD) begin
      fresh_wait_ff <= 12'h000;
    end else begin
      fresh_wait_ff <= fresh_wait_ff + 12'h001;
    end
  end
  fresh_sent_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    fresh_wait_ff < 12'(`VL_FRESH_WAIT_CYC)) else $error("fresh set not sent");
  ready_led_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    defect_ff |=> !O_READY_LED) else $error("ready lit while defective");
  link_led_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(conn_ff) |=> O_LINK_ACTIVE_INDICATOR) else $error("link indicator late");
  chan_check_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    chan_mismatch |=> defect_ff) else $error("channel mismatch missed");
  health_report_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (defect_ff && I_POWER_OK) |=> O_HEALTH == HEALTH_DEFECT) else $error("health wrong");
endmodule
`default_nettype wire

/* hw/vio_link_consts.svh */
// Constants for the virtual I/O link block.
`ifndef VIO_LINK_CONSTS_SVH
`define VIO_LINK_CONSTS_SVH
`define VL_NBITS 32
`define VL_CLK_HZ 50000000
`define VL_TBUS_MS 35
`define VL_TBUS_CYC ((`VL_TBUS_MS * `VL_CLK_HZ) / 1000)
`define VL_FRAME_BITS 70
`define VL_BIT_DIV 16
`define VL_TOUT_CYC 1000000
`define VL_FRESH_WAIT_CYC 1200
`define VL_SYNC_WORD 4'hA
`define VL_PEER_RUN_POS 32
`define VL_PEER_DEF_POS 33
`define VL_ADDR_CTRL 12'h000
`define VL_ADDR_OUT 12'h004
`define VL_ADDR_IN 12'h008
`define VL_ADDR_STAT 12'h00C
`define VL_ADDR_IRQ_STAT 12'h010
`define VL_ADDR_IRQ_MASK 12'h014
`define VL_ST_HEALTH_LSB 0
`define VL_ST_CONN_POS 2
`define VL_ST_PEER_RUN_POS 3
`define VL_IRQ_CONN_UP 0
`define VL_IRQ_CONN_LOST 1
`define VL_IRQ_DEFECT 2
`define VL_IRQ_RX 3
`endif

/* hw/vio_link_pkg.sv */
// Types for the virtual I/O link block.
package vio_link_pkg;
  typedef enum logic [1:0] {HEALTH_UNPOWERED = 2'h0, HEALTH_GOOD = 2'h1, HEALTH_DEFECT = 2'h2} health_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_LOAD = 4'h2,
    TX_SHIFT = 4'h4,
    TX_GAP = 4'h8
  } tx_state_t;
endpackage

/* tb/peer_link_model.sv */
// Peer link module model that sends frames cyclically on its transmit pair.
`timescale 1ns/10ps
`default_nettype none
`include "vio_link_consts.svh"
module peer_link_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Frame content.
  input wire logic i_run,
  input wire logic i_defect,
  input wire logic i_bad,
  input wire logic [31:0] i_data,
  // Transmit pair, wired crossed to the block's receive pair.
  output logic o_line
);
  logic [69:0] frame;
  logic [31:0] sent;
  initial begin
    o_line = 1'b0;
    forever begin
      @(posedge i_clk);
      if (!i_rst_n) begin
        // A line not yet driven by a live peer must not look like a steady level.
        o_line <= ~o_line;
      end else begin
        // A defective peer holds its outputs at zero.
        sent = i_defect ? 32'h00000000 : i_data;
        frame = {`VL_SYNC_WORD, i_run, i_defect, sent, i_bad ? sent : ~sent};
        for (int b = 69; b >= 0; b--) begin
          o_line <= frame[b];
          repeat (`VL_BIT_DIV) @(posedge i_clk);
        end
        o_line <= ~frame[0];
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the virtual I/O link block.
`timescale 1ns/10ps
`default_nettype none
`include "vio_link_consts.svh"
module tb_top;
  import vio_link_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, err, stop, irq, line_a, line_b, peer_line, rdy_led, link_led, fault_led;
  logic [31:0] prdata, rd;
  logic run = 1'b1;
  logic pwr_ok = 1'b1;
  logic loop_sel = 1'b0;
  logic p_def = 1'b0;
  logic p_bad = 1'b0;
  logic [31:0] p_data = 32'hA5C30F1E;
  health_t health;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  // Loop mode stands for a crossed cable back to the block itself.
  assign line_b = loop_sel ? line_a : peer_line;
  vio_link dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
    .I_CTRL_RUN(run), .I_POWER_OK(pwr_ok), .O_CTRL_STOP(stop), .O_IRQ(irq), .O_PAIR_A_POSITIVE(line_a),
    .I_PAIR_B_POSITIVE(line_b), .O_READY_LED(rdy_led), .O_LINK_ACTIVE_INDICATOR(link_led),
    .O_FAULT_LED(fault_led), .O_HEALTH(health));
  peer_link_model peer (.i_clk(clk), .i_rst_n(rst_n), .i_run(1'b1), .i_defect(p_def), .i_bad(p_bad),
    .i_data(p_data), .o_line(peer_line));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic frames(input int n);
    repeat (n * 1200) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d checked, %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'h0, "inputs before link");
    apb(1'b0, `VL_ADDR_STAT, 32'h0);
    chk(rd, 32'h00000001, "status after reset");
    chk({31'h0, rdy_led}, 32'h1, "ready led");
    chk({31'h0, link_led}, 32'h0, "link led off");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    for (int k = 0; k < 3000 && link_led !== 1'b1; k++) @(posedge clk);
    frames(1);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'hA5C30F1E, "peer outputs");
    apb(1'b0, `VL_ADDR_STAT, 32'h0);
    chk(rd, 32'h0000000D, "status linked");
    chk({31'h0, link_led}, 32'h1, "link led on");
    apb(1'b1, `VL_ADDR_IRQ_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    apb(1'b1, `VL_ADDR_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test link up done");
    p_bad <= 1'b1;
    p_data <= 32'h12345678;
    frames(3);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'hA5C30F1E, "bad frames ignored");
    p_bad <= 1'b0;
    frames(3);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'h12345678, "new peer outputs");
    p_def <= 1'b1;
    frames(3);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'h0, "defective peer sends zeros");
    apb(1'b0, `VL_ADDR_STAT, 32'h0);
    chk(rd, 32'h00000005, "peer defect shows stopped");
    chk({31'h0, stop}, 32'h0, "local keeps running");
    $display("test peer faults done");
    loop_sel <= 1'b1;
    apb(1'b1, `VL_ADDR_OUT, 32'h80000001);
    apb(1'b0, `VL_ADDR_OUT, 32'h0);
    chk(rd, 32'h80000001, "output register");
    frames(4);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'h80000001, "outputs sent back");
    apb(1'b0, `VL_ADDR_STAT, 32'h0);
    chk(rd, 32'h0000000D, "own run flag looped");
    run <= 1'b0;
    frames(3);
    apb(1'b0, `VL_ADDR_STAT, 32'h0);
    chk(rd, 32'h00000005, "stopped flag looped");
    apb(1'b0, `VL_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "control after stop");
    $display("test loop done");
    pwr_ok <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, stop}, 32'h1, "defect stops controller");
    chk({31'h0, fault_led}, 32'h1, "fault led");
    chk({31'h0, rdy_led}, 32'h0, "ready led off");
    chk({30'h0, health}, {30'h0, HEALTH_UNPOWERED}, "health unpowered");
    frames(4);
    apb(1'b0, `VL_ADDR_IN, 32'h0);
    chk(rd, 32'h0, "outputs zeroed");
    apb(1'b0, `VL_ADDR_OUT, 32'h0);
    chk(rd, 32'h0, "output register zeroed");
    pwr_ok <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, health}, {30'h0, HEALTH_DEFECT}, "health defect");
    chk({31'h0, stop}, 32'h1, "defect latched");
    $display("test defect done");
    report_and_stop();
  end
endmodule
`default_nettype wire
